// ### logic/mcrg_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcrg_defines.svh"
module mcrg_top
  import mcrg_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Avalon-MM slave
  input wire logic [31:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Per-module clock enables and resets
  output logic [MCRG_NMOD-1:0] MOD_OP_CLK_EN_O,
  output logic [MCRG_NMOD-1:0] MOD_BUS_CLK_EN_O,
  output logic [MCRG_NMOD-1:0] MOD_IF_CLK_EN_O,
  output logic [MCRG_NMOD-1:0] MOD_RST_O
);
  // ****************************************
  // Declarations
  // ****************************************
  mcrg_gate_if gif ();
  mcrg_bus_st_t state_ff;
  logic [31:0] rst1_ff;
  logic [31:0] rst2_ff;
  logic [31:0] en1_ff;
  logic [31:0] en2_ff;
  logic [7:0] div_ff;
  logic req;
  logic wr_go;
  logic [7:0] off;
  logic in_bank;
  logic [31:0] be_mask;
  logic [31:0] wd_m;
  logic [31:0] rd_mux;
  mcrg_vec_t en_all;
  mcrg_vec_t rst_all;

  // Offset match inside the bank window
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  // ****************************************
  // Address decode and write data
  // ****************************************
  // Only the upper address bits select the bank
  assign in_bank = (AVS_ADDRESS_I[`MCRG_BASE_HI_MSB:`MCRG_BASE_HI_LSB]
                   == `MCRG_BASE_ADDR >> `MCRG_BASE_HI_LSB);
  assign off = AVS_ADDRESS_I[7:0];
  // A request is taken once, in the idle state
  assign req = (AVS_READ_I | AVS_WRITE_I) & (state_ff == MCRG_IDLE);
  // Write lands at the edge the master sees waitrequest low, while it still holds the request
  assign wr_go = AVS_WRITE_I & (state_ff == MCRG_ACK) & in_bank;
  // Byte lanes widened to bit masks
  assign be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign wd_m = AVS_WRITEDATA_I & be_mask;
  assign en_all = {en2_ff, en1_ff};
  assign rst_all = {rst2_ff, rst1_ff};

  // ****************************************
  // Read multiplexer
  // ****************************************
  // Alias registers read back the live enable state
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (!in_bank)
      rd_mux = 32'h0000_0000;
    else if (hit(off, `MCRG_OFF_RST1))
      rd_mux = rst1_ff;
    else if (hit(off, `MCRG_OFF_RST2))
      rd_mux = rst2_ff;
    else if (hit(off, `MCRG_OFF_EN1) || hit(off, `MCRG_OFF_SET1) || hit(off, `MCRG_OFF_CLR1))
      rd_mux = en1_ff;
    else if (hit(off, `MCRG_OFF_EN2) || hit(off, `MCRG_OFF_SET2) || hit(off, `MCRG_OFF_CLR2))
      rd_mux = en2_ff;
    else if (hit(off, `MCRG_OFF_DIV))
      rd_mux = {24'h00_0000, div_ff};
    else
      rd_mux = 32'h0000_0000;
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  // Two states: waitrequest drops for exactly one cycle per request
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      state_ff <= MCRG_IDLE;
    else
      case (state_ff)
        MCRG_IDLE: if (req) state_ff <= MCRG_ACK;
        MCRG_ACK: state_ff <= MCRG_IDLE;
        default: state_ff <= MCRG_IDLE;
      endcase
  end

  // Waitrequest high by default, low in the answer cycle
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      AVS_WAITREQUEST_O <= 1'b1;
    else
      AVS_WAITREQUEST_O <= ~req;
  end

  // Read data captured with the request, zero for writes and holes
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      AVS_READDATA_O <= 32'h0000_0000;
    else if (req)
      AVS_READDATA_O <= AVS_READ_I ? rd_mux : 32'h0000_0000;
  end

  // ****************************************
  // Reset control registers
  // ****************************************
  // Reserved bits never store, so they read as zero
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      rst1_ff <= `MCRG_RST_RESET;
    else if (wr_go && hit(off, `MCRG_OFF_RST1))
      rst1_ff <= ((rst1_ff & ~be_mask) | wd_m) & `MCRG_RST1_RW_MASK;
  end

  // Second reset word has no known holes, all bits stored
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      rst2_ff <= `MCRG_RST_RESET;
    else if (wr_go && hit(off, `MCRG_OFF_RST2))
      rst2_ff <= (rst2_ff & ~be_mask) | wd_m;
  end

  // ****************************************
  // Enable registers and their aliases
  // ****************************************
  // Direct write, set alias and clear alias share one register
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      en1_ff <= `MCRG_EN_RESET;
    else if (wr_go && hit(off, `MCRG_OFF_EN1))
      en1_ff <= (en1_ff & ~be_mask) | wd_m;
    else if (wr_go && hit(off, `MCRG_OFF_SET1))
      en1_ff <= en1_ff | wd_m;
    else if (wr_go && hit(off, `MCRG_OFF_CLR1))
      en1_ff <= en1_ff & ~wd_m;
  end

  // Same scheme for the upper enable word
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      en2_ff <= `MCRG_EN_RESET;
    else if (wr_go && hit(off, `MCRG_OFF_EN2))
      en2_ff <= (en2_ff & ~be_mask) | wd_m;
    else if (wr_go && hit(off, `MCRG_OFF_SET2))
      en2_ff <= en2_ff | wd_m;
    else if (wr_go && hit(off, `MCRG_OFF_CLR2))
      en2_ff <= en2_ff & ~wd_m;
  end

  // Divider selects for bus and interface rates
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      div_ff <= `MCRG_DIV_RESET;
    else if (wr_go && hit(off, `MCRG_OFF_DIV) && AVS_BYTEENABLE_I[0])
      div_ff <= AVS_WRITEDATA_I[7:0] & `MCRG_DIV_RW_MASK;
  end

  // ****************************************
  // Clock dividers and gating
  // ****************************************
  assign gif.en = en_all;
  assign gif.rst = rst_all;

  // Bus rate, a power-of-two division of the operating rate
  mcrg_div u_bus_div
  (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .sel_i(div_ff[`MCRG_DIV_BUS_LSB +: 3]),
    .tick_o(gif.bus_tick)
  );

  // Interface rate divided from the same operating clock
  mcrg_div u_if_div
  (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .sel_i(div_ff[`MCRG_DIV_IF_LSB +: 3]),
    .tick_o(gif.if_tick)
  );

  mcrg_gate u_gate
  (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .gif(gif)
  );

  // Outputs are the gate flops themselves
  assign MOD_OP_CLK_EN_O = gif.op_en;
  assign MOD_BUS_CLK_EN_O = gif.bus_en;
  assign MOD_IF_CLK_EN_O = gif.if_en;
  assign MOD_RST_O = gif.mod_rst;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  chk_op_follows_en: assert property (
    ##1 (gif.op_en == $past(en_all)))
    else $error("operating enable does not follow enable bits");

  chk_gated_off_clk: assert property (
    ##1 (((gif.op_en | gif.bus_en | gif.if_en) & ~$past(en_all)) == '0))
    else $error("clock enable active for a disabled module");

  chk_disable_keeps: assert property (
    (wr_go && (hit(off, `MCRG_OFF_CLR1) || hit(off, `MCRG_OFF_CLR2))) |=> $stable(rst_all) [*2])
    else $error("disabling a module changed reset state");

  chk_set_alias_or: assert property (
    (wr_go && hit(off, `MCRG_OFF_SET1)) |=> (en1_ff == ($past(en1_ff) | $past(wd_m))))
    else $error("set alias did not set the written bits");

  chk_clr_alias_and: assert property (
    (wr_go && hit(off, `MCRG_OFF_CLR2)) |=> ((en2_ff & $past(wd_m)) == 32'h0000_0000))
    else $error("clear alias did not clear the written bits");

  chk_zero_no_effect: assert property (
    (wr_go && (hit(off, `MCRG_OFF_SET1) || hit(off, `MCRG_OFF_CLR1)))
    |=> (((en1_ff ^ $past(en1_ff)) & ~$past(wd_m)) == 32'h0000_0000))
    else $error("alias write disturbed an unselected enable bit");

  chk_rst_hold: assert property (
    (rst1_ff[31] && $stable(rst1_ff[31])) |=> MOD_RST_O[31])
    else $error("module not held in reset");

  chk_rst_release: assert property (
    $fell(rst_all[1]) |-> ##1 !MOD_RST_O[1] ##0 $past(MOD_RST_O[1]))
    else $error("module not released one cycle after reset bit clears");

  chk_rst1_read: assert property (
    (req && AVS_READ_I && in_bank && hit(off, `MCRG_OFF_RST1))
    |=> (!AVS_WAITREQUEST_O && AVS_READDATA_O == $past(rst1_ff)))
    else $error("reset register read wrong at offset zero");

  chk_reserved_zero: assert property (
    (rst1_ff & ~`MCRG_RST1_RW_MASK) == 32'h0000_0000)
    else $error("reserved reset bit became set");

  chk_if_from_op: assert property (
    (gif.if_en != '0) |-> ((gif.if_en & ~gif.op_en) == '0))
    else $error("interface enable without operating enable");

  chk_bus_on_tick: assert property (
    (gif.bus_en != '0) |-> $past(gif.bus_tick))
    else $error("bus enable outside a bus tick");

  chk_wait_one_cycle: assert property (
    req |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("waitrequest answer not exactly one cycle");

  chk_write_at_ack: assert property (
    wr_go |-> !AVS_WAITREQUEST_O)
    else $error("write landed outside the answer cycle");

  chk_rst_follows: assert property (
    RST_N_I |-> ##1 (MOD_RST_O == $past(rst_all)))
    else $error("module resets do not follow reset bits");

  chk_en1_direct: assert property (
    (wr_go && hit(off, `MCRG_OFF_EN1)) |=> (en1_ff == (($past(en1_ff) & ~$past(be_mask)) | $past(wd_m))))
    else $error("direct enable write did not land");

  chk_rst2_store: assert property (
    (wr_go && hit(off, `MCRG_OFF_RST2)) |=> (rst2_ff == (($past(rst2_ff) & ~$past(be_mask)) | $past(wd_m))))
    else $error("second reset word write did not land");

  chk_set2_alias: assert property (
    (wr_go && hit(off, `MCRG_OFF_SET2)) |=> ((en2_ff & $past(wd_m)) == $past(wd_m)))
    else $error("upper set alias did not set the written bits");

  chk_clr1_alias: assert property (
    (wr_go && hit(off, `MCRG_OFF_CLR1)) |=> ((en1_ff & $past(wd_m)) == 32'h0000_0000))
    else $error("lower clear alias did not clear the written bits");

  chk_div_reserved: assert property (
    (div_ff & ~`MCRG_DIV_RW_MASK) == 8'h00)
    else $error("reserved divider bit became set");
endmodule : mcrg_top
`default_nettype wire

// ### logic/mcrg_defines.svh
// Contract
// - Enable bit one supplies operating and bus clocks
// - Enable bit zero gates both clocks off
// - Disabling a module keeps its registers
// - Set alias ones set enable bits only
// - Clear alias ones clear enable bits only
// - Reset bit one holds module in reset
// - Reset bit zero releases the module
// - Bank decodes at fixed base, reset-1 at zero
// - Reset-1 fields rw, reset zero, reserved bits
// - Interface clock divided from operating clock
// - Register access runs on the bus clock (the bank here takes accesses on every CLOCK_I cycle, not on bus ticks)
`ifndef MCRG_DEFINES_SVH
`define MCRG_DEFINES_SVH

// ****************************************
// Bank placement
// ****************************************
`define MCRG_BASE_ADDR 32'h5000_0000
`define MCRG_BASE_HI_MSB 31
`define MCRG_BASE_HI_LSB 8

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MCRG_OFF_RST1 8'h00
`define MCRG_OFF_RST2 8'h04
`define MCRG_OFF_EN1 8'h08
`define MCRG_OFF_EN2 8'h0C
`define MCRG_OFF_SET1 8'h10
`define MCRG_OFF_SET2 8'h14
`define MCRG_OFF_CLR1 8'h18
`define MCRG_OFF_CLR2 8'h1C
`define MCRG_OFF_DIV 8'h20

// ****************************************
// Field layouts and reset values
// ****************************************
`define MCRG_RST1_RW_MASK 32'h9A77_FDFE
`define MCRG_RST_RESET 32'h0000_0000
`define MCRG_EN_RESET 32'h0000_0000
`define MCRG_DIV_BUS_LSB 0
`define MCRG_DIV_IF_LSB 4
`define MCRG_DIV_RESET 8'h00
`define MCRG_DIV_RW_MASK 8'h77

`endif

// ### logic/mcrg_pkg.sv
`default_nettype none
package mcrg_pkg;
  // Number of gated modules across both enable words
  localparam int MCRG_NMOD = 64;
  // Bus handshake states, gray along idle to answer
  typedef enum logic [1:0]
  {
    MCRG_IDLE = 2'b00,
    MCRG_ACK = 2'b01
  } mcrg_bus_st_t;
  typedef logic [MCRG_NMOD-1:0] mcrg_vec_t;
endpackage : mcrg_pkg
`default_nettype wire

// ### logic/mcrg_gate_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mcrg_gate_if;
  import mcrg_pkg::*;
  // Control from the register bank and the clock dividers
  mcrg_vec_t en;
  mcrg_vec_t rst;
  logic bus_tick;
  logic if_tick;
  // Registered per-module outputs
  mcrg_vec_t op_en;
  mcrg_vec_t bus_en;
  mcrg_vec_t if_en;
  mcrg_vec_t mod_rst;
  modport ctl (output en, rst, bus_tick, if_tick, input op_en, bus_en, if_en, mod_rst);
  modport gate (input en, rst, bus_tick, if_tick, output op_en, bus_en, if_en, mod_rst);
endinterface : mcrg_gate_if
`default_nettype wire

// ### logic/mcrg_div.sv
`timescale 1ns/10ps
`default_nettype none
module mcrg_div
  import mcrg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Divide by two to the power of sel
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [6:0] cnt_ff;
  logic [6:0] mask;

  // Low sel bits all ones marks the last cycle of a period
  assign mask = 7'((8'h01 << sel_i) - 8'h01);

  // Free-running count; no reset on change keeps it glitch-free
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_ff <= 7'h00;
    else
      cnt_ff <= cnt_ff + 7'h01;
  end

  // One-cycle enable pulse per divided period
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      tick_o <= 1'b0;
    else
      tick_o <= ((cnt_ff & mask) == mask);
  end
endmodule : mcrg_div
`default_nettype wire

// ### logic/mcrg_gate.sv
`timescale 1ns/10ps
`default_nettype none
module mcrg_gate
  import mcrg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register bank side
  mcrg_gate_if.gate gif
);
  // ****************************************
  // Per-module enables and resets
  // ****************************************
  for (genvar i = 0; i < MCRG_NMOD; i++)
  begin : g_mod
    // Operating clock enable follows the level bit only
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        gif.op_en[i] <= 1'b0;
      else
        gif.op_en[i] <= gif.en[i];
    end

    // Bus clock is a divided tick; the bank's register access runs every CLOCK_I cycle, not on it
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        gif.bus_en[i] <= 1'b0;
      else
        gif.bus_en[i] <= gif.en[i] & gif.bus_tick;
    end

    // Interface clock derived from the operating clock, never separate
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        gif.if_en[i] <= 1'b0;
      else
        gif.if_en[i] <= gif.en[i] & gif.if_tick;
    end

    // Reset level is independent of the enable, so gating never clears state
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        gif.mod_rst[i] <= 1'b1;
      else
        gif.mod_rst[i] <= gif.rst[i];
    end
  end
endmodule : mcrg_gate
`default_nettype wire

// ### testbench/test_module_clock_reset_gating.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcrg_defines.svh"
module test_module_clock_reset_gating
  import mcrg_pkg::*;
;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] adr = 32'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ben = 4'hF;
  logic [31:0] rdat;
  logic waitreq;
  logic [MCRG_NMOD-1:0] op_en;
  logic [MCRG_NMOD-1:0] bus_en;
  logic [MCRG_NMOD-1:0] if_en;
  logic [MCRG_NMOD-1:0] mod_rst;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] q;

  mcrg_top dut (.CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(ben), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq),
    .MOD_OP_CLK_EN_O(op_en), .MOD_BUS_CLK_EN_O(bus_en), .MOD_IF_CLK_EN_O(if_en), .MOD_RST_O(mod_rst));

  // 50 MHz clock
  always #10 clk = ~clk;

  // ****************************************
  // Reporting and bus helpers
  // ****************************************
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : check32

  task automatic check64(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : check64

  // Holds the request until waitrequest is seen low; bounded so a dead slave ends the run
  task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] d, input logic [3:0] be,
    input logic [31:0] base = `MCRG_BASE_ADDR);
    int n;
    n = 0;
    rd <= ~w;
    wr <= w;
    adr <= base | {24'h0, off};
    wdat <= d;
    ben <= be;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
    begin
      miscompares++;
      complete_run();
    end
    else
    begin
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] off, input logic [31:0] exp);
    bus(1'b0, off, 32'h0, 4'hF);
    check32(nm, exp, q);
  endtask : rchk

  // Looks at the module outputs mid-cycle, once the last edge has landed
  task automatic outs(input logic [63:0] exp_en, input logic [63:0] exp_rst);
    @(negedge clk);
    check64("op clock enables", exp_en, op_en);
    check64("module resets", exp_rst, mod_rst);
    @(posedge clk);
  endtask : outs

  // Counts enable pulses of one module over 32 cycles
  task automatic pulses(input logic ifc, input int b, output logic [31:0] n);
    n = 32'h0;
    repeat (32)
    begin
      @(posedge clk);
      n = n + {31'h0, ((ifc ? if_en[b] : bus_en[b]) === 1'b1)};
    end
  endtask : pulses

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_ctrl();
    bus(1'b1, `MCRG_OFF_RST1, 32'hFFFF_FFFF, 4'hF);
    rchk("reset word 1 fields", `MCRG_OFF_RST1, 32'h9A77_FDFE);
    bus(1'b1, `MCRG_OFF_RST2, 32'h8000_0001, 4'hF);
    outs(64'h0, 64'h8000_0001_9A77_FDFE);
    bus(1'b1, `MCRG_OFF_RST1, 32'h0, 4'hF);
    bus(1'b1, `MCRG_OFF_RST2, 32'h0, 4'hF);
    outs(64'h0, 64'h0);
  endtask : t_reset_ctrl

  task automatic t_alias();
    bus(1'b1, `MCRG_OFF_SET1, 32'hA5A5_0F0F, 4'hF);
    bus(1'b1, `MCRG_OFF_SET1, 32'h0000_00F0, 4'hF);
    rchk("enable word 1 after set", `MCRG_OFF_EN1, 32'hA5A5_0FFF);
    bus(1'b1, `MCRG_OFF_CLR1, 32'h0000_0F00, 4'hF);
    rchk("enable word 1 after clear", `MCRG_OFF_EN1, 32'hA5A5_00FF);
    // Only the enabled byte lane may reach the enable word
    bus(1'b1, `MCRG_OFF_SET1, 32'hFFFF_FFFF, 4'h4);
    rchk("set alias readback", `MCRG_OFF_SET1, 32'hA5FF_00FF);
    bus(1'b1, `MCRG_OFF_SET2, 32'h8000_0001, 4'hF);
    bus(1'b1, `MCRG_OFF_CLR2, 32'hFFFF_FFFE, 4'hF);
    rchk("enable word 2", `MCRG_OFF_EN2, 32'h0000_0001);
    outs(64'h0000_0001_A5FF_00FF, 64'h0);
  endtask : t_alias

  task automatic t_ticks();
    logic [31:0] n;
    bus(1'b1, `MCRG_OFF_DIV, 32'hFFFF_FFFF, 4'hF);
    rchk("divider config", `MCRG_OFF_DIV, 32'h0000_0077);
    bus(1'b1, `MCRG_OFF_DIV, 32'h0000_0032, 4'hF);
    repeat (2) @(posedge clk);
    pulses(1'b0, 0, n);
    check32("bus pulses module 0", 32'h0000_0008, n);
    pulses(1'b0, 32, n);
    check32("bus pulses module 32", 32'h0000_0008, n);
    pulses(1'b0, 8, n);
    check32("bus pulses module 8", 32'h0000_0000, n);
    pulses(1'b1, 0, n);
    check32("interface pulses module 0", 32'h0000_0004, n);
    pulses(1'b1, 9, n);
    check32("interface pulses module 9", 32'h0000_0000, n);
  endtask : t_ticks

  task automatic t_retain();
    bus(1'b1, `MCRG_OFF_RST1, 32'h0000_0006, 4'hF);
    bus(1'b1, `MCRG_OFF_CLR1, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, `MCRG_OFF_CLR2, 32'hFFFF_FFFF, 4'hF);
    outs(64'h0, 64'h6);
    rchk("reset word kept", `MCRG_OFF_RST1, 32'h0000_0006);
    bus(1'b1, `MCRG_OFF_EN1, 32'h1234_5678, 4'hF);
    outs(64'h1234_5678, 64'h6);
    bus(1'b1, `MCRG_OFF_RST1, 32'h0, 4'hF);
  endtask : t_retain

  task automatic t_decode();
    bus(1'b1, `MCRG_OFF_EN1, 32'hFFFF_FFFF, 4'hF, 32'h6000_0000);
    rchk("enable word after foreign write", `MCRG_OFF_EN1, 32'h1234_5678);
    bus(1'b0, `MCRG_OFF_EN1, 32'h0, 4'hF, 32'h6000_0000);
    check32("foreign read", 32'h0, q);
    rchk("unmapped offset", 8'h24, 32'h0);
    rchk("reset word at offset zero", 8'h00, 32'h0);
  endtask : t_decode

  // A second reset in mid-run must clear the bank and hold every module in reset
  task automatic t_midreset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    outs(64'h0, {MCRG_NMOD{1'b1}});
    rst_n <= 1'b1;
    @(posedge clk);
    outs(64'h0, 64'h0);
    rchk("enable word after reset", `MCRG_OFF_EN1, 32'h0);
    rchk("reset word 1 after reset", `MCRG_OFF_RST1, 32'h0);
  endtask : t_midreset

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    check64("module resets in reset", {MCRG_NMOD{1'b1}}, mod_rst);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    outs(64'h0, 64'h0);
    rchk("reset word 1 at start", `MCRG_OFF_RST1, 32'h0);
    t_reset_ctrl();
    t_alias();
    t_ticks();
    t_retain();
    t_decode();
    t_midreset();
    complete_run();
  end
endmodule : test_module_clock_reset_gating
`default_nettype wire
